//--- core/sar_adc_regs.vh
// constants for the successive-approximation converter sequencer
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH
`define SAR_BITS 12
`define SAR_INIT_CODE 12'h800
`define SAR_MSB_INDEX 4'hb
`define SAR_LSB_INDEX 4'h0
`define PAIR_NEG_MASK 4'h1
`define VERNIER_BITS 8
`define VERNIER_RESET 8'h80
`define CHAN_BITS 4
`define BIT_INTERVAL_CYCLES 8'h08
`define HOLD_SETTLE_CYCLES 8'h04
`endif

//--- core/bit_interval_timer.v
// interval timer that marks the end of each fixed-length step
`timescale 1ns/1ps
`default_nettype none
module bit_interval_timer (
    input wire mclk,
    input wire reset,
    input wire restart,
    input wire [7:0] length,
    output reg tick
);
    reg [7:0] count_reg;
    always @(posedge mclk) begin
        if (reset || restart) begin
            count_reg <= 8'h00;
            tick <= 1'b0;
        end else if (count_reg == length - 8'h01) begin
            count_reg <= 8'h00;
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- core/sar_adc_sequencer.v
// control sequencer for a 12-bit auto-zeroing successive-approximation converter
// Summary of operation
// - idle: sample-and-hold feedback closed, tracking input
// - start: open feedback, preamp drives comparator
// - then negative channel, or auto-zero if one-sided
// - feedback code starts at octal 4000
// - test bits MSB first down to LSB
// - latch comparator decision at each interval end
// - positive summing node drops the bit
// - after LSB, copy result to data buffer
// - vernier field is write-only, separate from result
// - vernier is 8-bit offset binary, +-2.5 LSB
// - 16 channels from two eight-way multiplexers
// - sampling enables the addressed multiplexer channel
// - one-sided hold: all channels off, auto-zero on
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.vh"
module sar_adc_sequencer (
    input wire mclk,
    input wire reset,
    input wire start,
    input wire [3:0] channel,
    input wire one_sided_input_mode,
    input wire vernier_write,
    input wire [7:0] vernier_data,
    input wire comparator_positive,
    output reg track_switch,
    output reg compare_switch,
    output reg autozero_switch,
    output reg [7:0] mux_low_enable,
    output reg [7:0] mux_high_enable,
    output reg [11:0] dac_code,
    output reg [7:0] vernier_code,
    output reg [11:0] result,
    output reg done,
    output reg busy
);
    // =========================================
    // input synchronisers
    // both pins arrive unrelated to mclk; only the second flop is ever read
    localparam SYNC_START = 0;
    localparam SYNC_COMP = 1;
    localparam SYNC_PINS = 2;
    wire [SYNC_PINS-1:0] pin_async = {comparator_positive, start};
    wire [SYNC_PINS-1:0] pin_synced;
    genvar g;
    generate
        for (g = 0; g < SYNC_PINS; g = g + 1) begin : pin_sync
            reg meta_reg;
            reg stable_reg;
            always @(posedge mclk) begin
                if (reset) begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end else begin
                    meta_reg <= pin_async[g];
                    stable_reg <= meta_reg;
                end
            end
            assign pin_synced[g] = stable_reg;
        end
    endgenerate

    // edge detector idles low like the pin, so leaving reset gives no false start
    reg start_seen_reg;
    always @(posedge mclk) begin
        if (reset) begin
            start_seen_reg <= 1'b0;
        end else begin
            start_seen_reg <= pin_synced[SYNC_START];
        end
    end
    wire start_edge = pin_synced[SYNC_START] & ~start_seen_reg;
    wire comp_pos = pin_synced[SYNC_COMP];

    // =========================================
    // sequencer
    localparam S_SAMPLE = 3'b001;
    localparam S_HOLD = 3'b010;
    localparam S_TEST = 3'b100;
    reg [2:0] state_reg;
    reg [3:0] bit_reg;
    reg [11:0] sar_reg;
    reg [3:0] chan_reg;
    reg pair_neg_reg;
    reg restart_reg;
    wire tick;

    function [7:0] one_hot8;
        input [2:0] sel;
        begin
            one_hot8 = 8'h01 << sel;
        end
    endfunction

    // single-bit mask for one position of the approximation word
    function [11:0] bit_mask;
        input [3:0] idx;
        begin
            bit_mask = 12'h001 << idx;
        end
    endfunction

    // next feedback code: settle the bit under test, then try the one below it
    function [11:0] next_trial;
        input [11:0] code;
        input [3:0] idx;
        input keep;
        begin
            next_trial = (code & ~bit_mask(idx)) | (keep ? bit_mask(idx) : 12'h000);
            if (idx != `SAR_LSB_INDEX) begin
                next_trial = next_trial | bit_mask(idx - 4'h1);
            end
        end
    endfunction

    // hold step and bit tests share one timer; only the length changes
    bit_interval_timer timer (
        .mclk(mclk),
        .reset(reset),
        .restart(restart_reg),
        .length(state_reg == S_HOLD ? `HOLD_SETTLE_CYCLES : `BIT_INTERVAL_CYCLES),
        .tick(tick)
    );

    always @(posedge mclk) begin
        if (reset) begin
            state_reg <= S_SAMPLE;
            bit_reg <= 4'h0;
            sar_reg <= 12'h000;
            chan_reg <= 4'h0;
            pair_neg_reg <= 1'b0;
            restart_reg <= 1'b1;
            result <= 12'h000;
            done <= 1'b0;
            busy <= 1'b0;
            dac_code <= 12'h000;
        end else begin
            restart_reg <= 1'b0;
            case (state_reg)
                S_SAMPLE: begin
                    chan_reg <= channel;
                    pair_neg_reg <= 1'b0;
                    // timer held clear while idle, so a stale tick cannot cut the hold short
                    restart_reg <= 1'b1;
                    if (start_edge) begin
                        state_reg <= S_HOLD;
                        done <= 1'b0;
                        busy <= 1'b1;
                    end
                end
                S_HOLD: begin
                    pair_neg_reg <= 1'b1;
                    if (tick) begin
                        state_reg <= S_TEST;
                        sar_reg <= `SAR_INIT_CODE;
                        dac_code <= `SAR_INIT_CODE;
                        bit_reg <= `SAR_MSB_INDEX;
                    end
                end
                S_TEST: begin
                    if (tick) begin
                        // decision held for the rest of the conversion
                        // timer runs on: a restart here would stretch every interval
                        sar_reg[bit_reg] <= ~comp_pos;
                        dac_code <= next_trial(sar_reg, bit_reg, ~comp_pos);
                        if (bit_reg == `SAR_LSB_INDEX) begin
                            result <= next_trial(sar_reg, bit_reg, ~comp_pos);
                            done <= 1'b1;
                            busy <= 1'b0;
                            state_reg <= S_SAMPLE;
                        end else begin
                            bit_reg <= bit_reg - 4'h1;
                        end
                    end
                end
                default: state_reg <= S_SAMPLE;
            endcase
        end
    end

    // =========================================
    // analog switch drive
    // the negative side of a pair is the odd channel next to the selected one
    wire tracking = (state_reg == S_SAMPLE);
    // gated by tracking: the pair flag clears one cycle after the sequencer goes idle
    wire use_neg = ~tracking & pair_neg_reg;
    wire [3:0] mux_sel = use_neg ? (chan_reg | `PAIR_NEG_MASK) : chan_reg;
    wire zeroing = use_neg & one_sided_input_mode;
    always @(posedge mclk) begin
        if (reset) begin
            track_switch <= 1'b1;
            compare_switch <= 1'b0;
            autozero_switch <= 1'b0;
            mux_low_enable <= 8'h00;
            mux_high_enable <= 8'h00;
        end else begin
            track_switch <= tracking;
            compare_switch <= ~tracking;
            autozero_switch <= zeroing;
            if (zeroing) begin
                mux_low_enable <= 8'h00;
                mux_high_enable <= 8'h00;
            end else begin
                // two eight-way parts share one output
                mux_low_enable <= mux_sel[3] ? 8'h00 : one_hot8(mux_sel[2:0]);
                mux_high_enable <= mux_sel[3] ? one_hot8(mux_sel[2:0]) : 8'h00;
            end
        end
    end

    // =========================================
    // vernier offset, offset binary: 8'h80 is zero offset
    // write-only: the read path returns the result, never this field
    always @(posedge mclk) begin
        if (reset) begin
            vernier_code <= `VERNIER_RESET;
        end else if (vernier_write) begin
            vernier_code <= vernier_data;
        end
    end
endmodule
`default_nettype wire

//--- tb/sar_seq_assertions.sv
// port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_seq_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic one_sided_input_mode,
    input wire logic vernier_write,
    input wire logic [7:0] vernier_data,
    input wire logic track_switch,
    input wire logic compare_switch,
    input wire logic autozero_switch,
    input wire logic [7:0] mux_low_enable,
    input wire logic [7:0] mux_high_enable,
    input wire logic [11:0] dac_code,
    input wire logic [7:0] vernier_code,
    input wire logic [11:0] result,
    input wire logic done,
    input wire logic busy
);
    // ====================
    // properties
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_back_to_track: assert property ($fell(busy) |=> track_switch) else $error("no tracking");
    a_hold_open: assert property (compare_switch |-> !track_switch) else $error("hold not open");
    a_zero_mode: assert property (autozero_switch |-> one_sided_input_mode && compare_switch) else $error("az");
    a_mux_dark: assert property (autozero_switch |-> (mux_low_enable | mux_high_enable) == 8'h00) else $error("mux");
    a_dac_seed: assert property ($rose(busy) |-> ##[1:8] dac_code == 12'h800) else $error("dac seed");
    a_conv_span: assert property ($rose(busy) |-> ##[96:112] $rose(done)) else $error("conv length");
    a_start_clear: assert property ($rose(busy) |-> !done) else $error("done kept");
    a_result_hold: assert property (done && $past(done) |-> $stable(result)) else $error("result moved");
    a_done_ends: assert property ($rose(done) |-> $fell(busy)) else $error("done while busy");
    a_vernier_load: assert property (vernier_write |=> vernier_code == $past(vernier_data)) else $error("vern");
    cover property ($rose(done) && one_sided_input_mode);
    cover property ($rose(done) && !one_sided_input_mode);
    cover property ($rose(busy));
endmodule
bind sar_adc_sequencer sar_seq_checker u_chk (.mclk, .reset, .one_sided_input_mode, .vernier_write, .vernier_data,
    .track_switch, .compare_switch, .autozero_switch, .mux_low_enable, .mux_high_enable, .dac_code,
    .vernier_code, .result, .done, .busy);
`default_nettype wire

//--- tb/analog_front_model.sv
// far-side analog front end: comparator against a held input level
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    input wire logic mclk,
    input wire logic compare_switch,
    input wire logic [11:0] dac_code,
    input wire logic [11:0] level,
    output logic comparator_positive
);
    logic wiggle = 1'h0;
    always @(posedge mclk) wiggle <= ~wiggle;
    // outside a conversion the output means nothing, so it wanders
    assign comparator_positive = compare_switch ? (dac_code > level) : wiggle;
endmodule
`default_nettype wire

//--- tb/sar_adc_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_tb;
    logic mclk = 1'h0, reset = 1'h1, start = 1'h0, one_sided_input_mode = 1'h0, vernier_write = 1'h0, done_q = 1'h0;
    logic [3:0] channel = 4'h0, ch;
    logic [7:0] vernier_data = 8'h00;
    logic [11:0] level = 12'h000, lv;
    logic [11:0] exp_q[$];
    wire comparator_positive, track_switch, compare_switch, autozero_switch, done, busy;
    wire [7:0] mux_low_enable, mux_high_enable, vernier_code;
    wire [11:0] dac_code, result;
    int error_cnt = 0, samples_checked = 0, cycles = 0;
    always #20 mclk = ~mclk;
    sar_adc_sequencer dut (.mclk, .reset, .start, .channel, .one_sided_input_mode, .vernier_write, .vernier_data,
        .comparator_positive, .track_switch, .compare_switch, .autozero_switch, .mux_low_enable,
        .mux_high_enable, .dac_code, .vernier_code, .result, .done, .busy);
    analog_front_model far (.mclk, .compare_switch, .dac_code, .level, .comparator_positive);
    task give_verdict;
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check_result(input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t result exp %h got %h", $time, exp, got);
        end
    endtask
    task check_mux(input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t mux exp %h got %h", $time, exp, got);
        end
    endtask
    task check_vernier(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t vernier exp %h got %h", $time, exp, got);
        end
    endtask
    // ====================
    // result watcher and hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        done_q <= done;
        if (done === 1'h1 && done_q === 1'h0) check_result(exp_q.pop_front(), result);
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict;
        end
    end
    // ====================
    // stimulus: edge codes first, then random levels
    initial begin
        void'($urandom(32'h4bd5));
        repeat (12) @(posedge mclk);
        reset <= 1'h0;
        #1 check_vernier(8'h80, vernier_code);
        for (int i = 0; i < 8; i++) begin
            lv = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
            ch = 4'($urandom);
            @(posedge mclk);
            level <= lv;
            channel <= ch;
            one_sided_input_mode <= i[0];
            vernier_data <= 8'($urandom);
            vernier_write <= 1'h1;
            exp_q.push_back(lv);
            @(posedge mclk);
            vernier_write <= 1'h0;
            start <= 1'h1;
            repeat (10) @(posedge mclk);
            start <= 1'h0;
            #1 check_mux(i[0] ? 16'h0000 : 16'h0001 << (ch | 4'h1), {mux_high_enable, mux_low_enable});
            check_vernier(vernier_data, vernier_code);
            // a second start while busy must be ignored
            repeat (2) @(posedge mclk);
            start <= 1'h1;
            for (int k = 0; k < 150 && done !== 1'h1; k++) @(posedge mclk);
            start <= 1'h0;
            repeat (4) @(posedge mclk);
            #1 check_mux(16'h0001 << ch, {mux_high_enable, mux_low_enable});
        end
        // a conversion that never finished leaves its note behind
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("mismatch t=%0t conversion never finished", $time);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
